// *** hw/phy_ext_page1_pkg.sv ***
/*
   constants for the first extended register page: indices, field positions,
   reset values, write masks and interrupt bit layout.
   assumes registers sit on a 32-bit apb word at byte address four times the index.
*/
package phy_ext_page1_pkg;

   // register indices, byte address is four times the index
   localparam logic [5:0]  IDX_GOOD_CRC    = 6'h12;
   localparam logic [5:0]  IDX_EXT_MODE    = 6'h13;
   localparam logic [5:0]  IDX_POWER_SAVE  = 6'h14;
   localparam logic [5:0]  IDX_PAGE        = 6'h1f;
   localparam logic [5:0]  IDX_WIN_LO      = 6'h10;
   localparam logic [5:0]  IDX_WIN_HI      = 6'h1e;
   localparam logic [5:0]  IDX_IRQ_STATUS  = 6'h20;
   localparam logic [5:0]  IDX_IRQ_MASK    = 6'h21;

   // page select values
   localparam logic [15:0] PAGE_MAIN       = 16'h0000;
   localparam logic [15:0] PAGE_EXT1       = 16'h0001;
   localparam logic [15:0] PAGE_RST        = 16'h0000;

   // good crc counter fields
   localparam int          CRC_FLAG_BIT    = 15;
   localparam logic [13:0] CRC_CNT_LAST    = 14'h270f;
   localparam logic [13:0] CRC_CNT_RST     = 14'h0000;

   // extended mode control fields
   localparam int          EXT_BLINK_BIT   = 11;
   localparam int          EXT_MDI_LSB     = 2;
   localparam logic [15:0] EXT_MODE_RST    = 16'h0000;
   localparam logic [15:0] EXT_MODE_WMASK  = 16'h080c;

   // power save and link control fields
   localparam int          PS_CEXT_BIT     = 15;
   localparam int          PS_SLEEP_LSB    = 13;
   localparam int          PS_WAKE_LSB     = 11;
   localparam int          PS_ADDR_REV_BIT = 9;
   localparam int          PS_MEDIA_LSB    = 6;
   localparam int          PS_NOPRE_BIT    = 5;
   localparam int          PS_DS_EN_BIT    = 4;
   localparam int          PS_DS_THR_LSB   = 2;
   localparam int          PS_DS_STAT_BIT  = 1;
   localparam logic [15:0] PS_RST          = 16'ha004;
   localparam logic [15:0] PS_WMASK        = 16'hfa3c;

   // downshift threshold for code zero
   localparam logic [2:0]  DS_THR_BASE     = 3'h2;

   // interrupt status and mask layout
   localparam int          IRQ_W           = 4;
   localparam int          IRQ_GOOD_PKT    = 0;
   localparam int          IRQ_CNT_WRAP    = 1;
   localparam int          IRQ_DOWNSHIFT   = 2;
   localparam int          IRQ_HOLD_REL    = 3;
   localparam logic [3:0]  IRQ_RST         = 4'h0;

endpackage : phy_ext_page1_pkg

// *** hw/downshift_monitor.sv ***
/*
   counts failed gigabit autonegotiation attempts and flags a needed downshift.
   assumes fail and link pulses come from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module downshift_monitor (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // settings
   input  wire logic       ds_enable,
   input  wire logic [1:0] ds_thresh,
   // link events
   input  wire logic       aneg_fail_1000,
   input  wire logic       link_up,
   // result
   output var  logic       ds_required
);

   typedef struct packed {
      logic [2:0] fails;
      logic       required;
   } ds_state_t;

   ds_state_t  q;
   ds_state_t  n;
   logic [2:0] thr;

   always_comb begin
      n   = q;
      thr = phy_ext_page1_pkg::DS_THR_BASE + {1'b0, ds_thresh};
      if (!ds_enable) begin
         n.fails    = 3'h0;
         n.required = 1'b0;
      end else if (!q.required) begin
         if (link_up) begin
            n.fails = 3'h0;
         end else if (aneg_fail_1000) begin
            n.fails = q.fails + 3'h1;
            if (q.fails + 3'h1 >= thr) begin
               n.required = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign ds_required = q.required;

endmodule : downshift_monitor

`default_nettype wire

// *** hw/phy_ext_page1_regs.sv ***
/*
   first extended register page with page select and main-space stand-in,
   reached over apb, plus interrupt status and mask.
   assumes good packet, fail and link inputs come from ref_clk logic;
   the low-power hold pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - writing 0x0001 to register 31 maps extended page one into registers 16-30
// - writing 0x0000 to register 31 returns registers 16-30 to main space
// - with page one selected, registers 16-30 reach page-one registers only
// - registers 0-15 behave the same whatever page is selected
// - counter bit 15 flags a packet since last read, cleared by read
// - bits 13:0 count good copper packets modulo 10000, cleared by read
// - the good count wraps from 9999 to zero, never saturating
// - mode bit 11 set blinks leds after low-power hold release
// - crossover field: 00 auto, 10 force mdi, 11 force mdi-x, 01 reserved
// - power-save bit 15, reset one, disables carrier extension
// - sleep timer bits 14:13 pick 1 to 4 seconds, reset 01
// - wake timer bits 12:11 pick 160/400/800 ms or 2 s, reset 00
// - read-only bits 7:6 show media: none, copper, serdes, reserved
// - bit 5 lets 10base-t raise rx_dv without preamble
// - bit 4 enables link speed downshift after failed gigabit negotiation
// - threshold bits 3:2 select 2 to 5 failed attempts, reset 01
// - read-only bit 1 shows downshift required or done
module phy_ext_page1_regs (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // phy status inputs
   input  wire logic        good_crc_pkt,
   input  wire logic [1:0]  media_status,
   input  wire logic        aneg_fail_1000,
   input  wire logic        link_up,
   input  wire logic        low_power_hold_input,
   // control outputs
   output var  logic        led_blink_start,
   output var  logic [1:0]  mdi_mode,
   output var  logic        carrier_ext_disable,
   output var  logic [1:0]  sleep_timer_sel,
   output var  logic [1:0]  wake_timer_sel,
   output var  logic        addr_reversal,
   output var  logic        no_preamble_en,
   output var  logic        downshift_en,
   output var  logic [1:0]  downshift_thresh,
   output var  logic        downshift_status,
   output var  logic        ext_page1_active,
   // interrupt
   output var  logic        irq
);

   typedef struct packed {
      logic [15:0]                           page;
      logic                                  page1_act;
      logic [30:0][15:0]                     main_regs;
      logic                                  crc_flag;
      logic [13:0]                           crc_cnt;
      logic [15:0]                           ext_mode;
      logic [15:0]                           ps_ctrl;
      logic [1:0]                            media;
      logic                                  ds_stat;
      logic                                  hold_meta;
      logic                                  hold_sync;
      logic                                  hold_prev;
      logic [phy_ext_page1_pkg::IRQ_W-1:0]   irq_status;
      logic [phy_ext_page1_pkg::IRQ_W-1:0]   irq_mask;
      logic                                  irq;
      logic                                  blink;
      logic                                  pready;
      logic                                  pslverr;
      logic [31:0]                           prdata;
   } state_t;

   state_t      q;
   state_t      n;
   logic        ds_required;
   logic [5:0]  idx;
   logic        page1;
   logic        setup;
   logic        access;
   logic        hit_err;
   logic [15:0] rdata;
   logic [15:0] wdata;
   logic        rd_crc;
   logic        hold_rel;
   logic [phy_ext_page1_pkg::IRQ_W-1:0] events;

   downshift_monitor u_downshift (
      .ref_clk        (ref_clk),
      .srst           (srst),
      .ds_enable      (q.ps_ctrl[phy_ext_page1_pkg::PS_DS_EN_BIT]),
      .ds_thresh      (q.ps_ctrl[phy_ext_page1_pkg::PS_DS_THR_LSB +: 2]),
      .aneg_fail_1000 (aneg_fail_1000),
      .link_up        (link_up),
      .ds_required    (ds_required)
   );

   always_comb begin
      n      = q;
      idx    = paddr[7:2];
      wdata  = pwdata[15:0];
      page1  = (q.page == phy_ext_page1_pkg::PAGE_EXT1);
      setup  = psel && !penable;
      access = psel && penable && q.pready;
      events = '0;

      // read decode, done in the setup cycle
      hit_err = 1'b0;
      rdata   = 16'h0000;
      if (paddr[1:0] != 2'h0) begin
         hit_err = 1'b1;
      end else if (idx == phy_ext_page1_pkg::IDX_PAGE) begin
         rdata = q.page;
      end else if (idx == phy_ext_page1_pkg::IDX_IRQ_STATUS) begin
         rdata = {12'h000, q.irq_status};
      end else if (idx == phy_ext_page1_pkg::IDX_IRQ_MASK) begin
         rdata = {12'h000, q.irq_mask};
      end else if (idx > phy_ext_page1_pkg::IDX_WIN_HI) begin
         hit_err = 1'b1;
      end else if (page1 && idx >= phy_ext_page1_pkg::IDX_WIN_LO) begin
         if (idx == phy_ext_page1_pkg::IDX_GOOD_CRC) begin
            rdata = {q.crc_flag, 1'b0, q.crc_cnt};
         end else if (idx == phy_ext_page1_pkg::IDX_EXT_MODE) begin
            rdata = q.ext_mode & phy_ext_page1_pkg::EXT_MODE_WMASK;
         end else if (idx == phy_ext_page1_pkg::IDX_POWER_SAVE) begin
            rdata = q.ps_ctrl & phy_ext_page1_pkg::PS_WMASK;
            rdata[phy_ext_page1_pkg::PS_MEDIA_LSB +: 2] = q.media;
            rdata[phy_ext_page1_pkg::PS_DS_STAT_BIT]    = q.ds_stat;
         end else begin
            rdata = 16'h0000;
         end
      end else begin
         rdata = q.main_regs[idx[4:0]];
      end

      // bus answer: ready in the first access cycle
      n.pready  = setup;
      n.pslverr = setup && hit_err;
      if (setup) begin
         n.prdata  = pwrite ? 32'h0000_0000 : {16'h0000, rdata};
      end

      // good crc counter, read-clear taken with the setup snapshot
      rd_crc = setup && !pwrite && !hit_err && page1
               && (idx == phy_ext_page1_pkg::IDX_GOOD_CRC);
      if (rd_crc) begin
         n.crc_flag = 1'b0;
         n.crc_cnt  = phy_ext_page1_pkg::CRC_CNT_RST;
      end
      if (good_crc_pkt) begin
         n.crc_flag = 1'b1;
         events[phy_ext_page1_pkg::IRQ_GOOD_PKT] = 1'b1;
         if (rd_crc) begin
            n.crc_cnt = 14'h0001;
         end else if (q.crc_cnt == phy_ext_page1_pkg::CRC_CNT_LAST) begin
            n.crc_cnt = phy_ext_page1_pkg::CRC_CNT_RST;
            events[phy_ext_page1_pkg::IRQ_CNT_WRAP] = 1'b1;
         end else begin
            n.crc_cnt = q.crc_cnt + 14'h0001;
         end
      end

      // status captured from the phy core
      n.media   = media_status;
      n.ds_stat = ds_required;
      if (ds_required && !q.ds_stat) begin
         events[phy_ext_page1_pkg::IRQ_DOWNSHIFT] = 1'b1;
      end

      // low-power hold pin: two-flop synchroniser then release edge
      n.hold_meta = low_power_hold_input;
      n.hold_sync = q.hold_meta;
      n.hold_prev = q.hold_sync;
      hold_rel    = q.hold_prev && !q.hold_sync;
      n.blink     = hold_rel && q.ext_mode[phy_ext_page1_pkg::EXT_BLINK_BIT];
      if (hold_rel) begin
         events[phy_ext_page1_pkg::IRQ_HOLD_REL] = 1'b1;
      end

      // writes take effect at the completing edge
      if (access && pwrite && !q.pslverr) begin
         if (idx == phy_ext_page1_pkg::IDX_PAGE) begin
            n.page = wdata;
         end else if (idx == phy_ext_page1_pkg::IDX_IRQ_STATUS) begin
            n.irq_status = q.irq_status & ~wdata[phy_ext_page1_pkg::IRQ_W-1:0];
         end else if (idx == phy_ext_page1_pkg::IDX_IRQ_MASK) begin
            n.irq_mask = wdata[phy_ext_page1_pkg::IRQ_W-1:0];
         end else if (page1 && idx >= phy_ext_page1_pkg::IDX_WIN_LO) begin
            if (idx == phy_ext_page1_pkg::IDX_EXT_MODE) begin
               n.ext_mode = wdata & phy_ext_page1_pkg::EXT_MODE_WMASK;
            end else if (idx == phy_ext_page1_pkg::IDX_POWER_SAVE) begin
               n.ps_ctrl = wdata & phy_ext_page1_pkg::PS_WMASK;
            end
         end else begin
            n.main_regs[idx[4:0]] = wdata;
         end
      end

      // page flag kept in a flop so the output needs no decode
      n.page1_act = (n.page == phy_ext_page1_pkg::PAGE_EXT1);

      // sticky status, a new event wins over a clear
      n.irq_status = n.irq_status | events;
      n.irq        = |(n.irq_status & n.irq_mask);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q            <= '0;
         q.page       <= phy_ext_page1_pkg::PAGE_RST;
         q.ext_mode   <= phy_ext_page1_pkg::EXT_MODE_RST;
         q.ps_ctrl    <= phy_ext_page1_pkg::PS_RST;
         q.irq_status <= phy_ext_page1_pkg::IRQ_RST;
         q.irq_mask   <= phy_ext_page1_pkg::IRQ_RST;
      end else begin
         q <= n;
      end
   end

   // outputs straight from state
   assign prdata              = q.prdata;
   assign pready              = q.pready;
   assign pslverr             = q.pslverr;
   assign led_blink_start     = q.blink;
   assign mdi_mode            = q.ext_mode[phy_ext_page1_pkg::EXT_MDI_LSB +: 2];
   assign carrier_ext_disable = q.ps_ctrl[phy_ext_page1_pkg::PS_CEXT_BIT];
   assign sleep_timer_sel     = q.ps_ctrl[phy_ext_page1_pkg::PS_SLEEP_LSB +: 2];
   assign wake_timer_sel      = q.ps_ctrl[phy_ext_page1_pkg::PS_WAKE_LSB +: 2];
   assign addr_reversal       = q.ps_ctrl[phy_ext_page1_pkg::PS_ADDR_REV_BIT];
   assign no_preamble_en      = q.ps_ctrl[phy_ext_page1_pkg::PS_NOPRE_BIT];
   assign downshift_en        = q.ps_ctrl[phy_ext_page1_pkg::PS_DS_EN_BIT];
   assign downshift_thresh    = q.ps_ctrl[phy_ext_page1_pkg::PS_DS_THR_LSB +: 2];
   assign downshift_status    = q.ds_stat;
   assign ext_page1_active    = q.page1_act;
   assign irq                 = q.irq;

endmodule : phy_ext_page1_regs

`default_nettype wire

// *** verification/phy_ext_page1_props.sv ***
/*
   checker for phy_ext_page1_regs: apb answer timing and control outputs after writes.
   assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_ext_page1_props (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        srst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // controls
   input wire logic [1:0]  mdi_mode,
   input wire logic        carrier_ext_disable,
   input wire logic [1:0]  sleep_timer_sel,
   input wire logic [1:0]  wake_timer_sel,
   input wire logic        no_preamble_en,
   input wire logic        downshift_en,
   input wire logic [1:0]  downshift_thresh,
   input wire logic        ext_page1_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic wdone;
   assign wdone = psel && penable && pready && pwrite;
   a_ready_after_setup: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   a_err_only_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_page_select: assert property (wdone && paddr == 8'h7c
      |=> ext_page1_active == (pwdata[15:0] == 16'h0001))
      else $error("page active wrong after page write");
   a_mdi_field: assert property (wdone && ext_page1_active && paddr == 8'h4c
      |=> mdi_mode == pwdata[3:2])
      else $error("mdi mode wrong");
   a_cext_bit: assert property (wdone && ext_page1_active && paddr == 8'h50
      |=> carrier_ext_disable == pwdata[15])
      else $error("carrier ext wrong");
   a_timer_fields: assert property (wdone && ext_page1_active && paddr == 8'h50
      |=> sleep_timer_sel == pwdata[14:13] && wake_timer_sel == pwdata[12:11])
      else $error("timer selects wrong");
   a_nopre_bit: assert property (wdone && ext_page1_active && paddr == 8'h50
      |=> no_preamble_en == pwdata[5])
      else $error("no preamble wrong");
   a_ds_fields: assert property (wdone && ext_page1_active && paddr == 8'h50
      |=> downshift_en == pwdata[4] && downshift_thresh == pwdata[3:2])
      else $error("downshift settings wrong");
endmodule : phy_ext_page1_props
bind phy_ext_page1_regs phy_ext_page1_props i_props (.ref_clk(ref_clk), .srst(srst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .mdi_mode(mdi_mode),
   .carrier_ext_disable(carrier_ext_disable), .sleep_timer_sel(sleep_timer_sel),
   .wake_timer_sel(wake_timer_sel), .no_preamble_en(no_preamble_en),
   .downshift_en(downshift_en), .downshift_thresh(downshift_thresh),
   .ext_page1_active(ext_page1_active));
`default_nettype wire

// *** verification/phy_ext_page1_regs_tb.sv ***
/*
   self-checking bench for phy_ext_page1_regs driven over apb.
   assumes the design answers one access cycle after setup.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_ext_page1_regs_tb;
   logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        good_crc_pkt, aneg_fail_1000, link_up, low_power_hold_input, e;
   logic [1:0]  media_status, mdi_mode, sleep_timer_sel, wake_timer_sel, downshift_thresh;
   logic        led_blink_start, carrier_ext_disable, addr_reversal, no_preamble_en;
   logic        downshift_en, downshift_status, ext_page1_active, irq, seen;
   int          err_count, n_tests;
   phy_ext_page1_regs i_phy_ext_page1_regs (.ref_clk(ref_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .good_crc_pkt(good_crc_pkt),
      .media_status(media_status), .aneg_fail_1000(aneg_fail_1000), .link_up(link_up),
      .low_power_hold_input(low_power_hold_input), .led_blink_start(led_blink_start),
      .mdi_mode(mdi_mode), .carrier_ext_disable(carrier_ext_disable),
      .sleep_timer_sel(sleep_timer_sel), .wake_timer_sel(wake_timer_sel),
      .addr_reversal(addr_reversal), .no_preamble_en(no_preamble_en),
      .downshift_en(downshift_en), .downshift_thresh(downshift_thresh),
      .downshift_status(downshift_status), .ext_page1_active(ext_page1_active), .irq(irq));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task wrap_up;
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task rd(input string n, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(n, x, r);
   endtask : rd
   task crc(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         good_crc_pkt <= 1'b1;
      end
      @(posedge ref_clk);
      good_crc_pkt <= 1'b0;
   endtask : crc
   task t_paging;
      apb(1'b1, 8'h48, 32'h1234); apb(1'b1, 8'h04, 32'h00ab); apb(1'b1, 8'h7c, 32'h1);
      @(posedge ref_clk);
      chk("active", 1, ext_page1_active);
      rd("counter", 8'h48, 32'h0);
      rd("reg1", 8'h04, 32'hab);
      rd("psreset", 8'h50, 32'ha004);
      chk("cext", 1, carrier_ext_disable);
      chk("sleep", 1, sleep_timer_sel);
      apb(1'b1, 8'h7c, 32'h0);
      rd("main18", 8'h48, 32'h1234);
      chk("active", 0, ext_page1_active);
   endtask : t_paging
   task t_count;
      apb(1'b1, 8'h7c, 32'h1); apb(1'b1, 8'h84, 32'h1);
      crc(3);
      chk("irq", 1, irq);
      rd("count", 8'h48, 32'h8003);
      rd("cleared", 8'h48, 32'h0);
      apb(1'b1, 8'h80, 32'h1);
      @(posedge ref_clk);
      chk("irqclr", 0, irq);
      crc(10000);
      rd("wrap", 8'h48, 32'h8000);
      rd("status", 8'h80, 32'h3);
      apb(1'b1, 8'h80, 32'hf);
   endtask : t_count
   task t_modes;
      apb(1'b1, 8'h4c, 32'hffff);
      rd("mode", 8'h4c, 32'h080c);
      apb(1'b1, 8'h4c, 32'h0808);
      @(posedge ref_clk);
      chk("mdi", 2, mdi_mode);
      media_status <= 2'b01;
      apb(1'b1, 8'h50, 32'hffff);
      rd("ps", 8'h50, 32'hfa7c);
      chk("addrrev", 1, addr_reversal);
      apb(1'b1, 8'h50, 32'h0010);
      repeat (2) begin
         @(posedge ref_clk) aneg_fail_1000 <= 1'b1;
         @(posedge ref_clk) aneg_fail_1000 <= 1'b0;
         repeat (3) @(posedge ref_clk);
      end
      rd("downshift", 8'h50, 32'h0052);
      chk("dsstat", 1, downshift_status);
   endtask : t_modes
   task t_blink;
      seen = 1'b0;
      @(posedge ref_clk) low_power_hold_input <= 1'b1;
      repeat (4) @(posedge ref_clk);
      low_power_hold_input <= 1'b0;
      repeat (10) @(posedge ref_clk) seen |= led_blink_start;
      chk("blink", 1, seen);
      apb(1'b0, 8'h88, 32'h0);
      chk("unmapped", 1, e);
   endtask : t_blink
   initial begin
      err_count = 0; n_tests = 0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h0; pwdata = 32'h0; good_crc_pkt = 1'b0; aneg_fail_1000 = 1'b0;
      link_up = 1'b0; low_power_hold_input = 1'b0; media_status = 2'b00;
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      t_paging;
      t_count;
      t_modes;
      t_blink;
      wrap_up;
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      err_count++;
      wrap_up;
   end
endmodule : phy_ext_page1_regs_tb
`default_nettype wire
